/* common/kad_map.vh */
// Purpose: Shared constants of the key table action decoder
// Assumes: 100 MHz system clock
// Notes:   Definitions only; included by bare name
`ifndef KAD_MAP_VH
`define KAD_MAP_VH
// Clock rate
`define KAD_CLK_MHZ        100
// Matrix timing, figures in their own units, counts derived
`define KAD_SCAN_MS        4
`define KAD_SCAN_CYC       (`KAD_SCAN_MS * 1000 * `KAD_CLK_MHZ)
`define KAD_SETTLE_US      40
`define KAD_SETTLE_CYC     (`KAD_SETTLE_US * `KAD_CLK_MHZ)
`define KAD_DEB_LAST       2'h2
// Cell timeout unit
`define KAD_CELL_UNIT_MS   100
`define KAD_CELL_UNIT_CYC  (`KAD_CELL_UNIT_MS * 1000 * `KAD_CLK_MHZ)
// Entry pages
`define KAD_PG_STD         8'h00
`define KAD_PG_MACRO       8'h02
`define KAD_PG_MOUSE       8'h03
`define KAD_PG_MODCOMBO    5'h1C
// Macro layout
`define KAD_MODE_CELL      8'h02
`define KAD_OFS_MODE       5'h00
`define KAD_OFS_TMO        5'h01
`define KAD_OFS_SEQ        5'h02
`define KAD_SEQ_LAST       5'h1D
// Key codes used by the decoder
`define KAD_KEY_DEL_FWD    8'h4C
`define KAD_KEY_LEFT       8'h50
`define KAD_KEY_RIGHT      8'h4F
`define KAD_KEY_SHIFT1     8'hFF
`define KAD_KEY_SHIFT2     8'hFE
`define KAD_MOD_FIRST      5'h1C
// Mouse codes, low byte of the mouse page
`define KAD_MS_MOVE_HI     6'h00
`define KAD_MS_BTN_HI      5'h02
// Acceleration
`define KAD_STEP_MIN       8'h01
`define KAD_STEP_MAX       8'h10
`define KAD_ACC_RAMP       4'h7
`endif

/* rtl/kad_mem.v */
// Purpose: Key table or macro store with registered read
// Assumes: One write port, one read port, same clock
// Notes:   INIT_KIND 1 preloads the default key table, 2 a default cell macro
`timescale 1ns/1ps
`default_nettype none
module kad_mem #(
  parameter W         = 16,
  parameter AW        = 8,
  parameter INIT_KIND = 0
) (
  input  wire          clk,
  input  wire          we,
  input  wire [AW-1:0] waddr,
  input  wire [W-1:0]  wdata,
  input  wire [AW-1:0] raddr,
  output reg  [W-1:0]  rdata
);
  reg [W-1:0] mem [0:(1<<AW)-1]; // Storage array
  integer     i;                 // Preload index
  reg [31:0]  ini;               // Preload word before sizing, W up to 32

  ////////////////////////////////////////////////////////////////////////
  // Default key table: index = {table, drive line, sense line}
  function [15:0] def_key;
    input [7:0] a;
    reg   [2:0] x;
    reg   [2:0] y;
    begin
      x = a[5:3];
      y = a[2:0];
      def_key = 16'h0000;
      if (y == 3'h7 && x == 3'h0) begin
        def_key = 16'h00FF;              // Shift to second table, all tables
      end else if (y == 3'h7 && x == 3'h1) begin
        def_key = 16'h00FE;              // Shift to third table, all tables
      end else if (a[7:6] == 2'h0) begin
        if (x >= 3'h3 && y <= 3'h4) begin
          def_key = {8'h00, 8'h04 + {2'h0, y, 3'h0} - {3'h0, y, 2'h0}
                     + {3'h0, y} + {5'h00, x} - 8'h03}; // Letters a..y
        end else if (x <= 3'h2 && y <= 3'h2) begin
          def_key = {8'h00, 8'h24 + {5'h00, x} - {4'h0, y, 1'b0} - {5'h00, y}};
        end else if (y == 3'h5 && x == 3'h3) begin
          def_key = 16'h001D;            // z
        end else if (y == 3'h5 && x == 3'h4) begin
          def_key = 16'h002C;            // Space
        end else if (y == 3'h5 && x == 3'h1) begin
          def_key = 16'h0052;            // Up arrow
        end else if (y == 3'h6 && x <= 3'h2) begin
          def_key = (x == 3'h0) ? 16'h0050 : (x == 3'h1) ? 16'h0051 : 16'h004F;
        end else if (y == 3'h6 && x == 3'h6) begin
          def_key = 16'h00E0;            // Left control
        end else if (y == 3'h7 && x == 3'h6) begin
          def_key = 16'h00E1;            // Left shift
        end
      end else if (a[7:6] == 2'h1 && y == 3'h3 && x == 3'h0) begin
        def_key = 16'hE01B;              // Control plus x
      end else if (a[7:6] == 2'h2 && y <= 3'h1 && x <= 3'h2) begin
        case ({y[0], x})
          4'h0:    def_key = 16'h0310;   // Left button
          4'h1:    def_key = 16'h0303;   // Move up
          4'h2:    def_key = 16'h0311;   // Right button
          4'h8:    def_key = 16'h0301;   // Move left
          4'h9:    def_key = 16'h0302;   // Move down
          default: def_key = 16'h0300;   // Move right
        endcase
      end else if (a[7:6] == 2'h2 && y == 3'h2 && x == 3'h1) begin
        def_key = 16'h0200;              // Cell macro 0
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Preload: used unchanged until overwritten through the write port
  initial begin
    for (i = 0; i < (1<<AW); i = i + 1) begin
      if (INIT_KIND == 1) begin
        ini = {16'h0000, def_key(i[7:0])};
      end else if (INIT_KIND == 2 && i < 8) begin
        ini = (i == 0) ? 32'h2 : (i == 1) ? 32'hA : (i < 7) ? i + 2 : 32'h0; // Cell a..e
      end else begin
        ini = 32'h0;
      end
      mem[i] = ini[W-1:0];
    end
  end

  // Write and registered read
  always @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule
`default_nettype wire

/* rtl/kad_top.v */
// Purpose: Scans an 8x8 key matrix and turns table entries into reports
// Assumes: Single clock REF_CLK at 100 MHz, asynchronous active-low reset
// Notes:   One held standard key slot; taps go out as make then break
`timescale 1ns/1ps
`default_nettype none
`include "kad_map.vh"
// Notes on behaviour
// - Sixteen-bit entry per key; upper byte picks page
// - Macro page: low byte numbers a 32-byte macro
// - Mode byte two runs a multi-tap cell macro
// - Second byte is timeout in 100 ms units
// - On timeout the last character is kept
// - Zero timeout expires immediately
// - Last thirty bytes are the cycled key codes
// - First press: first code then left arrow
// - Timeout without press sends right arrow
// - Other cell key in time: right arrow first
// - Same key in time: delete, next code, left
// - Zero next code wraps to the first
// - Mouse page low codes move cursor while held
// - Codes 10h-17h are mouse buttons one-eight
// - Movement step follows an acceleration curve
// - Pages E0h-E7h: modifier plus low-byte key
// - Combo modifier and key in one report
// - Preloaded default table until replaced
// - Scan every 4 ms; accept after three scans
// - Wait 40 us after drive before sampling
module kad_top #(
  parameter [31:0] SCAN_CYC      = `KAD_SCAN_CYC,
  parameter [31:0] CELL_UNIT_CYC = `KAD_CELL_UNIT_CYC,
  parameter [31:0] SETTLE_CYC    = `KAD_SETTLE_CYC     // Must fit the 12-bit settle timer
) (
  input  wire        REF_CLK,
  input  wire        ARST_N,
  input  wire [7:0]  MATRIX_SENSE,
  output reg  [7:0]  MATRIX_DRIVE,
  input  wire        TBL_WE,
  input  wire [7:0]  TBL_WADDR,
  input  wire [15:0] TBL_WDATA,
  input  wire        MAC_WE,
  input  wire [9:0]  MAC_WADDR,
  input  wire [7:0]  MAC_WDATA,
  output reg         RPT_VALID,
  output reg  [7:0]  RPT_MOD,
  output reg  [7:0]  RPT_KEY,
  output reg         MOUSE_VALID,
  output reg  [7:0]  MOUSE_BTN,
  output reg  [7:0]  MOUSE_DX,
  output reg  [7:0]  MOUSE_DY
);
  // Decoder states, one-hot
  localparam [5:0] S_IDLE = 6'h01;
  localparam [5:0] S_KDEC = 6'h02;
  localparam [5:0] S_MMOD = 6'h04;
  localparam [5:0] S_MTMO = 6'h08;
  localparam [5:0] S_MCOD = 6'h10;
  localparam [5:0] S_EMIT = 6'h20;

  reg  [31:0] sc_cnt_r;         // Scan interval timer
  reg         scanning_r;       // A matrix pass is running
  reg  [2:0]  row_r;            // Active drive line
  reg  [2:0]  srow_r;           // Drive line of the latest sample
  reg  [11:0] st_cnt_r;         // Settle timer after drive
  reg         sample_r;         // One-cycle sample strobe
  reg         tick_r;           // Scan start pulse, also paces mouse
  reg  [7:0]  s1_r;             // Sense synchroniser stage 1
  reg  [7:0]  s2_r;             // Stage 2
  reg  [7:0]  s3_r;             // Stage 3
  reg  [7:0]  filt_r;           // Sense after stages 2 and 3 agree
  wire [63:0] deb_w;            // Debounced key states
  reg  [63:0] done_r;           // Key states already decoded
  reg  [5:0]  state_r;          // Decoder state
  reg  [5:0]  kp_r;             // Key poll pointer
  reg         press_r;          // Event is a press
  reg         shift1_r;         // table_shift_first held
  reg         shift2_r;         // table_shift_second held
  reg  [7:0]  mod_r;            // Plain modifiers held
  reg  [7:0]  cmb_r;            // Combo modifiers held
  reg  [4:0]  mac_r;            // Macro being run
  reg  [7:0]  tmo_r;            // Timeout of that macro
  reg  [4:0]  nidx_r;           // Sequence index to send
  reg  [1:0]  kind_r;           // 0 fresh, 1 same key, 2 other key
  reg         pend_r;           // Cell timeout running
  reg  [4:0]  cell_mac_r;       // Macro owning the timeout
  reg  [4:0]  cell_idx_r;       // Index of last sent code
  reg  [31:0] pre_r;            // 100 ms prescaler
  reg  [7:0]  units_r;          // Remaining timeout units
  reg  [31:0] q_r;              // Tap queue, head in low byte
  reg  [2:0]  qn_r;             // Taps left
  reg         ph_r;             // Tap phase: make or break
  reg  [3:0]  mv_r;             // Move keys held: right left down up
  reg         btn_evt_r;        // Button state changed
  reg  [7:0]  step_r;           // Current movement step
  reg  [3:0]  ramp_r;           // Reports at this step
  reg  [7:0]  ktab_raddr;       // Key table read address
  reg  [9:0]  mac_raddr;        // Macro read address
  wire [15:0] ktab_rdata;       // Entry of polled key
  wire [7:0]  mac_rdata;        // Macro byte
  wire [7:0]  page_w;           // Entry page
  wire [7:0]  low_w;            // Entry low byte
  wire [1:0]  tbl_w;            // Table in use

  assign page_w = ktab_rdata[15:8];
  assign low_w  = ktab_rdata[7:0];
  assign tbl_w  = shift2_r ? 2'h2 : (shift1_r ? 2'h1 : 2'h0);

  ////////////////////////////////////////////////////////////////////////
  // Stores: default tables preloaded, writable for a custom table
  kad_mem #(.W(16), .AW(8), .INIT_KIND(1)) u_ktab (
    .clk   (REF_CLK),
    .we    (TBL_WE),
    .waddr (TBL_WADDR),
    .wdata (TBL_WDATA),
    .raddr (ktab_raddr),
    .rdata (ktab_rdata)
  );
  kad_mem #(.W(8), .AW(10), .INIT_KIND(2)) u_mac (
    .clk   (REF_CLK),
    .we    (MAC_WE),
    .waddr (MAC_WADDR),
    .wdata (MAC_WDATA),
    .raddr (mac_raddr),
    .rdata (mac_rdata)
  );

  ////////////////////////////////////////////////////////////////////////
  // Scan sequencer: one pass per interval, settle before each sample
  always @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      sc_cnt_r     <= 32'h0;
      scanning_r   <= 1'b0;
      row_r        <= 3'h0;
      srow_r       <= 3'h0;
      st_cnt_r     <= 12'h000;
      sample_r     <= 1'b0;
      tick_r       <= 1'b0;
      MATRIX_DRIVE <= 8'h00;
    end else begin
      sample_r <= 1'b0;
      tick_r   <= 1'b0;
      if (sc_cnt_r == SCAN_CYC - 32'h1) begin
        sc_cnt_r     <= 32'h0;
        tick_r       <= 1'b1;
        scanning_r   <= 1'b1;
        row_r        <= 3'h0;
        st_cnt_r     <= 12'h000;
        MATRIX_DRIVE <= 8'h01;
      end else begin
        sc_cnt_r <= sc_cnt_r + 32'h1;
        if (scanning_r) begin
          if (st_cnt_r == SETTLE_CYC[11:0] - 12'h001) begin
            sample_r <= 1'b1;
            srow_r   <= row_r;
            st_cnt_r <= 12'h000;
            row_r    <= row_r + 3'h1;
            // Last line sampled: release all drive lines
            if (row_r == 3'h7) begin
              scanning_r   <= 1'b0;
              MATRIX_DRIVE <= 8'h00;
            end else begin
              MATRIX_DRIVE <= {MATRIX_DRIVE[6:0], 1'b0};
            end
          end else begin
            st_cnt_r <= st_cnt_r + 12'h001;
          end
        end
      end
    end
  end

  // Sense pins: three stages, a bit changes once stages 2 and 3 agree
  always @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      s1_r   <= 8'h00;
      s2_r   <= 8'h00;
      s3_r   <= 8'h00;
      filt_r <= 8'h00;
    end else begin
      s1_r   <= MATRIX_SENSE;
      s2_r   <= s1_r;
      s3_r   <= s2_r;
      filt_r <= (s2_r & s3_r) | (filt_r & (s2_r | s3_r));
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Per-key debounce: a new level must hold for three samples
  genvar k;
  generate
    for (k = 0; k < 64; k = k + 1) begin : g_deb
      reg [1:0] cnt_r; // Samples that disagreed in a row
      reg       st_r;  // Accepted level
      assign deb_w[k] = st_r;
      always @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
          cnt_r <= 2'h0;
          st_r  <= 1'b0;
        end else if (sample_r && srow_r == k / 8) begin
          // Row pointer has already moved on when the strobe is seen
          if (filt_r[k % 8] == st_r) begin
            cnt_r <= 2'h0;
          end else if (cnt_r == `KAD_DEB_LAST) begin
            st_r  <= ~st_r;
            cnt_r <= 2'h0;
          end else begin
            cnt_r <= cnt_r + 2'h1;
          end
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Read addresses follow the decoder state; data arrive one cycle later
  always @* begin
    ktab_raddr = {tbl_w, kp_r};
    case (state_r)
      S_KDEC:  mac_raddr = {low_w[4:0], `KAD_OFS_MODE};
      S_MMOD:  mac_raddr = {mac_r, `KAD_OFS_TMO};
      S_MCOD:  mac_raddr = {mac_r, `KAD_OFS_SEQ};
      default: mac_raddr = {mac_r, `KAD_OFS_SEQ + nidx_r};
    endcase
    if (state_r == S_MTMO) begin
      mac_raddr = {mac_r, `KAD_OFS_SEQ
                   + (((pend_r && cell_mac_r == mac_r) && cell_idx_r != `KAD_SEQ_LAST)
                      ? cell_idx_r + 5'h01 : 5'h00)};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Decoder: polls key changes, decodes entries, runs cell macros
  always @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state_r    <= S_IDLE;
      kp_r       <= 6'h00;
      done_r     <= 64'h0;
      press_r    <= 1'b0;
      shift1_r   <= 1'b0;
      shift2_r   <= 1'b0;
      mod_r      <= 8'h00;
      cmb_r      <= 8'h00;
      mac_r      <= 5'h00;
      tmo_r      <= 8'h00;
      nidx_r     <= 5'h00;
      kind_r     <= 2'h0;
      pend_r     <= 1'b0;
      cell_mac_r <= 5'h00;
      cell_idx_r <= 5'h00;
      pre_r      <= 32'h0;
      units_r    <= 8'h00;
      q_r        <= 32'h0;
      qn_r       <= 3'h0;
      ph_r       <= 1'b0;
      mv_r       <= 4'h0;
      btn_evt_r  <= 1'b0;
      MOUSE_BTN  <= 8'h00;
      RPT_VALID  <= 1'b0;
      RPT_MOD    <= 8'h00;
      RPT_KEY    <= 8'h00;
    end else begin
      RPT_VALID <= 1'b0;
      btn_evt_r <= 1'b0;
      // Timeout counter runs down while a cell character is pending
      if (pend_r && units_r != 8'h00) begin
        if (pre_r == CELL_UNIT_CYC - 32'h1) begin
          pre_r   <= 32'h0;
          units_r <= units_r - 8'h01;
        end else begin
          pre_r <= pre_r + 32'h1;
        end
      end
      case (state_r)
        S_IDLE: begin
          // Expiry first, so a stale cursor never shifts the next char
          if (pend_r && units_r == 8'h00) begin
            pend_r <= 1'b0;
            q_r    <= {24'h0, `KAD_KEY_RIGHT};
            qn_r   <= 3'h1;
            ph_r   <= 1'b0;
            state_r <= S_EMIT;
          end else if (deb_w[kp_r] != done_r[kp_r]) begin
            done_r[kp_r] <= deb_w[kp_r];
            press_r      <= deb_w[kp_r];
            state_r      <= S_KDEC;
          end else begin
            kp_r <= kp_r + 6'h01;
          end
        end
        S_KDEC: begin
          state_r <= S_IDLE;
          kp_r    <= kp_r + 6'h01;
          if (page_w == `KAD_PG_STD) begin
            if (low_w == `KAD_KEY_SHIFT1) begin
              shift1_r <= press_r;
            end else if (low_w == `KAD_KEY_SHIFT2) begin
              shift2_r <= press_r;
            end else if (low_w[7:3] == `KAD_MOD_FIRST) begin
              mod_r[low_w[2:0]]   <= press_r;
              RPT_MOD             <= mod_r | cmb_r;
              RPT_MOD[low_w[2:0]] <= press_r;
              RPT_VALID           <= 1'b1;
            end else if (low_w != 8'h00) begin
              RPT_KEY   <= press_r ? low_w : 8'h00;
              RPT_MOD   <= mod_r | cmb_r;
              RPT_VALID <= 1'b1;
            end
          end else if (page_w[7:3] == `KAD_PG_MODCOMBO) begin
            // Modifier and key go out together in one report
            cmb_r[page_w[2:0]]   <= press_r;
            RPT_MOD              <= mod_r | cmb_r;
            RPT_MOD[page_w[2:0]] <= press_r;
            RPT_KEY              <= press_r ? low_w : 8'h00;
            RPT_VALID            <= 1'b1;
          end else if (page_w == `KAD_PG_MOUSE) begin
            if (low_w[7:2] == `KAD_MS_MOVE_HI) begin
              mv_r[low_w[1:0]] <= press_r;
            end else if (low_w[7:3] == `KAD_MS_BTN_HI) begin
              MOUSE_BTN[low_w[2:0]] <= press_r;
              btn_evt_r             <= 1'b1;
            end
          end else if (page_w == `KAD_PG_MACRO && press_r) begin
            mac_r   <= low_w[4:0];
            state_r <= S_MMOD;
          end
        end
        S_MMOD: begin
          state_r <= (mac_rdata == `KAD_MODE_CELL) ? S_MTMO : S_IDLE;
        end
        S_MTMO: begin
          tmo_r <= mac_rdata;
          if (pend_r && cell_mac_r == mac_r) begin
            kind_r <= 2'h1;
            nidx_r <= (cell_idx_r != `KAD_SEQ_LAST) ? cell_idx_r + 5'h01 : 5'h00;
          end else begin
            kind_r <= pend_r ? 2'h2 : 2'h0;
            nidx_r <= 5'h00;
          end
          state_r <= S_MCOD;
        end
        S_MCOD: begin
          if (mac_rdata == 8'h00 && nidx_r != 5'h00) begin
            nidx_r <= 5'h00;
          end else if (mac_rdata == 8'h00) begin
            state_r <= S_IDLE;
          end else begin
            // Timeout restarts on every accepted cell press
            pend_r     <= 1'b1;
            cell_mac_r <= mac_r;
            cell_idx_r <= nidx_r;
            pre_r      <= 32'h0;
            units_r    <= tmo_r;
            ph_r       <= 1'b0;
            state_r    <= S_EMIT;
            if (kind_r == 2'h0) begin
              q_r  <= {16'h0, `KAD_KEY_LEFT, mac_rdata};
              qn_r <= 3'h2;
            end else begin
              q_r  <= {8'h0, `KAD_KEY_LEFT, mac_rdata,
                       (kind_r == 2'h1) ? `KAD_KEY_DEL_FWD : `KAD_KEY_RIGHT};
              qn_r <= 3'h3;
            end
          end
        end
        S_EMIT: begin
          // Each tap is a make report then a break report
          RPT_VALID <= 1'b1;
          RPT_MOD   <= mod_r | cmb_r;
          ph_r      <= ~ph_r;
          if (!ph_r) begin
            RPT_KEY <= q_r[7:0];
          end else begin
            RPT_KEY <= 8'h00;
            q_r     <= {8'h00, q_r[31:8]};
            qn_r    <= qn_r - 3'h1;
            if (qn_r == 3'h1) begin
              state_r <= S_IDLE;
            end
          end
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Mouse reports: one per scan tick while moving, or on a button change
  always @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      step_r      <= `KAD_STEP_MIN;
      ramp_r      <= 4'h0;
      MOUSE_VALID <= 1'b0;
      MOUSE_DX    <= 8'h00;
      MOUSE_DY    <= 8'h00;
    end else begin
      MOUSE_VALID <= btn_evt_r;
      MOUSE_DX    <= 8'h00;
      MOUSE_DY    <= 8'h00;
      if (mv_r == 4'h0) begin
        step_r <= `KAD_STEP_MIN;
        ramp_r <= 4'h0;
      end else if (tick_r) begin
        MOUSE_VALID <= 1'b1;
        MOUSE_DX    <= (mv_r[0] ? step_r : 8'h00) - (mv_r[1] ? step_r : 8'h00);
        MOUSE_DY    <= (mv_r[2] ? step_r : 8'h00) - (mv_r[3] ? step_r : 8'h00);
        // Short presses stay fine, held presses speed up
        if (ramp_r == `KAD_ACC_RAMP) begin
          ramp_r <= 4'h0;
          if (step_r != `KAD_STEP_MAX) begin
            step_r <= step_r + 8'h01;
          end
        end else begin
          ramp_r <= ramp_r + 4'h1;
        end
      end
    end
  end
endmodule
`default_nettype wire

/* sim/kad_keys.sv */
// Purpose: Key switch model closing sense lines per driven line
// Assumes: Sense lines pulled low, key closed reads high
// Notes:   Combinational, like a real switch matrix
`timescale 1ns/1ps
`default_nettype none
module kad_keys (
  input  wire logic [7:0]  drive,
  input  wire logic [63:0] down,
  output var  logic [7:0]  sense
);
  // Key index is drive*8+sense; idle lines fall to the pull-down
  always_comb begin
    sense = 8'h00;
    for (int r = 0; r < 8; r++)
      if (drive[r]) sense = sense | down[r*8 +: 8];
  end
endmodule
`default_nettype wire

/* sim/kad_chk_assertions.sv */
// Purpose: Port relations of the action decoder
// Assumes: One clock, async active-low reset
// Notes:   Bound into every decoder top
`timescale 1ns/1ps
`default_nettype none
module kad_chk #(
  parameter int SETTLE_CYC = 4000
) (
  input wire logic       REF_CLK,
  input wire logic       ARST_N,
  input wire logic [7:0] MATRIX_DRIVE,
  input wire logic       RPT_VALID,
  input wire logic [7:0] RPT_MOD,
  input wire logic [7:0] RPT_KEY,
  input wire logic       MOUSE_VALID,
  input wire logic [7:0] MOUSE_DX,
  input wire logic [7:0] MOUSE_DY
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!ARST_N);
  logic [12:0] held_r; // Cycles the drive value has stood
  ////////////////////////////////////////////////////////////////
  // Saturates so a long idle gap cannot wrap into the window
  always @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) held_r <= 13'h0000;
    else if ($changed(MATRIX_DRIVE)) held_r <= 13'h0000;
    else if (held_r != 13'h1FFF) held_r <= held_r + 13'h0001;
  end
  sequence s_brk; RPT_VALID && RPT_KEY == 8'h00; endsequence
  sequence s_mk; RPT_VALID && RPT_KEY != 8'h00; endsequence
  sequence s_lft; RPT_VALID && RPT_KEY == 8'h50; endsequence
  logic mv; // A drive line is active
  assign mv = (MATRIX_DRIVE != 8'h00);
  property p_onehot; $onehot0(MATRIX_DRIVE); endproperty
  property p_order; ($changed(MATRIX_DRIVE) && $past(mv) && mv)
    |-> MATRIX_DRIVE == ($past(MATRIX_DRIVE) << 1); endproperty
  property p_stand; ($changed(MATRIX_DRIVE) && $past(mv))
    |-> held_r inside {[SETTLE_CYC-2:SETTLE_CYC+1]}; endproperty
  property p_right; RPT_VALID && RPT_KEY == 8'h4F |=> s_brk; endproperty
  property p_del; RPT_VALID && RPT_KEY == 8'h4C
    |=> s_brk ##[1:2] s_mk ##1 s_brk ##1 s_lft; endproperty
  property p_left; s_lft |-> $past(RPT_VALID) && $past(RPT_KEY) == 8'h00; endproperty
  property p_hold; !RPT_VALID |-> $stable(RPT_MOD) && $stable(RPT_KEY); endproperty
  property p_dx; !MOUSE_VALID |-> MOUSE_DX == 8'h00 && MOUSE_DY == 8'h00; endproperty
  a_onehot: assert property (p_onehot) else $error("drive not one-hot");
  a_order: assert property (p_order) else $error("drive order wrong");
  a_stand: assert property (p_stand) else $error("drive wait wrong");
  a_right: assert property (p_right) else $error("right tap broken");
  a_del: assert property (p_del) else $error("delete sequence broken");
  a_left: assert property (p_left) else $error("left without break");
  a_hold: assert property (p_hold) else $error("report moved alone");
  a_dx: assert property (p_dx) else $error("motion outside report");
endmodule
bind kad_top kad_chk #(.SETTLE_CYC(SETTLE_CYC)) u_chk (.REF_CLK, .ARST_N, .MATRIX_DRIVE, .RPT_VALID,
  .RPT_MOD, .RPT_KEY, .MOUSE_VALID, .MOUSE_DX, .MOUSE_DY);
`default_nettype wire

/* sim/tb_top.sv */
// Purpose: Scenario bench of the action decoder
// Assumes: Short scan, settle and timeout units, keys on drive line 0
// Notes:   Each key change waits out the debounce
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        REF_CLK = 1'b0;
  logic        ARST_N = 1'b0;
  logic [63:0] down = 64'h0; // Keys held closed
  logic        TBL_WE = 1'b0;
  logic [7:0]  TBL_WADDR = 8'h00;
  logic [15:0] TBL_WDATA = 16'h0000;
  logic        MAC_WE = 1'b0;
  logic [9:0]  MAC_WADDR = 10'h000;
  logic [7:0]  MAC_WDATA = 8'h00;
  wire  [7:0]  MATRIX_SENSE, MATRIX_DRIVE, RPT_MOD, RPT_KEY;
  wire  [7:0]  MOUSE_BTN, MOUSE_DX, MOUSE_DY;
  wire         RPT_VALID, MOUSE_VALID;
  int          miscompares = 0;
  int          samples_checked = 0;
  int          cyc = 0;
  logic [7:0]  taps[$]; // Make codes seen on the keyboard report
  logic [7:0]  mdx = 8'h00; // x of the first mouse report with nonzero x
  logic [7:0]  mdy = 8'h00; // y of the first mouse report with nonzero x
  // Full eight-line pass fits inside one scan interval
  kad_top #(.SCAN_CYC(32'd1000), .CELL_UNIT_CYC(32'd200), .SETTLE_CYC(32'd100)) dut (
    .REF_CLK, .ARST_N,
    .MATRIX_SENSE, .MATRIX_DRIVE, .TBL_WE, .TBL_WADDR, .TBL_WDATA, .MAC_WE,
    .MAC_WADDR, .MAC_WDATA, .RPT_VALID, .RPT_MOD, .RPT_KEY, .MOUSE_VALID,
    .MOUSE_BTN, .MOUSE_DX, .MOUSE_DY);
  kad_keys u_keys (.drive(MATRIX_DRIVE), .down(down), .sense(MATRIX_SENSE));
  initial forever #5 REF_CLK = ~REF_CLK;
  ////////////////////////////////////////////////////////////////
  // Tap log and hang guard
  always @(posedge REF_CLK) begin
    if (RPT_VALID === 1'b1 && RPT_KEY !== 8'h00) taps.push_back(RPT_KEY);
    if (MOUSE_VALID === 1'b1 && mdx == 8'h00) begin
      mdx <= MOUSE_DX;
      mdy <= MOUSE_DY;
    end
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      miscompares++;
      conclude();
    end
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Compares the logged taps, oldest first, then empties the log
  task automatic chk_taps(input logic [23:0] e, input int n);
    chk(16'(taps.size()), 16'(n));
    for (int i = 0; i < n; i++) chk({8'h00, taps[i]}, {8'h00, e[8*(n-1-i) +: 8]});
    taps.delete();
  endtask
  // One write strobe to the key table (m=0) or macro store (m=1)
  task automatic wr(input logic m, input logic [9:0] a, input logic [15:0] d);
    @(posedge REF_CLK);
    TBL_WE <= !m;
    MAC_WE <= m;
    TBL_WADDR <= a[7:0];
    MAC_WADDR <= a;
    TBL_WDATA <= d;
    MAC_WDATA <= d[7:0];
    @(posedge REF_CLK);
    TBL_WE <= 1'b0;
    MAC_WE <= 1'b0;
  endtask
  // Three row-0 samples plus sync fit well inside this wait
  task automatic keys(input logic [63:0] v);
    @(posedge REF_CLK);
    down <= v;
    repeat (10000) @(posedge REF_CLK);
  endtask
  ////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_combo();
    keys(64'h03);
    chk({8'h00, RPT_MOD}, 16'h0002);
    chk({8'h00, RPT_KEY}, 16'h0004);
    chk({8'h00, MOUSE_BTN}, 16'h0004);
    taps.delete();
  endtask
  // Short timeout of the preloaded macro runs out inside the wait
  task automatic t_cell_tmo();
    keys(64'h04);
    chk({8'h00, RPT_MOD}, 16'h0000);
    chk({8'h00, MOUSE_BTN}, 16'h0000);
    chk_taps(24'h04504F, 3);
  endtask
  task automatic t_cell_first();
    keys(64'h08);
    chk_taps(24'h1E50, 2);
  endtask
  // Second code is zero, so the repeat wraps to the first
  task automatic t_cell_again();
    keys(64'h00);
    keys(64'h08);
    chk_taps(24'h4C1E50, 3);
  endtask
  // First report of a held right key moves one minimum step
  task automatic t_mouse();
    keys(64'h10);
    chk({mdx, mdy}, 16'h0100);
  endtask
  task automatic conclude();
    $display("checked=%0d miscompares=%0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge REF_CLK);
    ARST_N <= 1'b1;
    wr(1'b0, 10'h000, 16'hE104);
    wr(1'b0, 10'h001, 16'h0312);
    wr(1'b0, 10'h002, 16'h0200);
    wr(1'b0, 10'h003, 16'h0201);
    wr(1'b0, 10'h004, 16'h0300);
    wr(1'b1, 10'h020, 16'h0002);
    wr(1'b1, 10'h021, 16'h00FF);
    wr(1'b1, 10'h022, 16'h001E);
    wr(1'b1, 10'h023, 16'h0000);
    t_combo();
    t_cell_tmo();
    t_cell_first();
    t_cell_again();
    t_mouse();
    conclude();
  end
endmodule
`default_nettype wire
